//--- src/rsp_device.sv
// Slave end of the RTC two-wire port: protocol engine and 26-byte store.
// Assumes clk_link runs free; rst and pwrReady come from the clk_sys domain.
module rsp_device (
  input wire logic clk_sys,        // System clock
  input wire logic rst,            // Synchronous reset, active high
  input wire logic clk_link,       // Link-side sampling clock
  input wire logic pwrReady,       // Power-up sequence finished
  output logic wrStrobe,           // One-cycle pulse per written byte
  output logic [7:0] wrAddr,       // Location of last write
  output logic [7:0] wrData,       // Value of last write
  rsp_if.device bus                // Two-wire link
);

  // ==========================================================
  // Reset and level synchronisers (link domain)
  logic rstM, rstL, rdyM, rdyQ;
  logic sclM, sclQ, sclP;
  logic sdaM, sdaQ, sdaP;
  // Both come from clk_sys; no reset here so rst itself can cross
  always_ff @(posedge clk_link)
  begin
    rstM <= rst;
    rstL <= rstM;
    rdyM <= pwrReady;
    rdyQ <= rdyM;
  end

  // Idle bus reads high; holding that in reset avoids a false start
  always_ff @(posedge clk_link)
  begin
    if (rstL)
    begin
      sclM <= 1'b1;
      sclQ <= 1'b1;
      sclP <= 1'b1;
      sdaM <= 1'b1;
      sdaQ <= 1'b1;
      sdaP <= 1'b1;
    end
    else
    begin
      sclM <= bus.scl;
      sclQ <= sclM;
      sclP <= sclQ;
      sdaM <= bus.sda;
      sdaQ <= sdaM;
      sdaP <= sdaQ;
    end
  end

  // ==========================================================
  // Bus conditions
  logic startSeen, stopSeen, sclRise, sclFall;
  assign startSeen = sclQ & sclP & sdaP & ~sdaQ;
  assign stopSeen = sclQ & sclP & ~sdaP & sdaQ;
  assign sclRise = sclQ & ~sclP;
  assign sclFall = ~sclQ & sclP;

  // ==========================================================
  // Protocol engine
  rsp_pkg::rsp_dstate_t state;
  rsp_pkg::rsp_kind_t kind;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn, txByte, ptr, memRd;
  logic rdMode, masterAck, byteDone;
  logic [7:0] mem [rsp_pkg::MEM_DEPTH];
  assign byteDone = (state == rsp_pkg::DS_RX) && sclFall && (bitCnt == rsp_pkg::BYTE_BITS);
  assign memRd = (ptr <= rsp_pkg::MEM_LAST) ? mem[ptr[4:0]] : 8'h00;

  always_ff @(posedge clk_link)
  begin
    if (rstL)
    begin
      state <= rsp_pkg::DS_IDLE;
      kind <= rsp_pkg::K_DEV;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txByte <= 8'h00;
      rdMode <= 1'b0;
      masterAck <= 1'b0;
    end
    else if (stopSeen)
      state <= rsp_pkg::DS_IDLE;
    else if (startSeen)
    begin
      // Starts while power-up is pending are dropped, engine stays put
      if (rdyQ)
      begin
        state <= rsp_pkg::DS_RX;
        kind <= rsp_pkg::K_DEV;
        bitCnt <= 4'h0;
      end
    end
    else
    begin
      case (state)
        rsp_pkg::DS_RX:
        begin
          if (sclRise)
          begin
            shiftIn <= {shiftIn[6:0], sdaQ};
            bitCnt <= bitCnt + 4'h1;
          end
          else if (byteDone)
          begin
            if (kind == rsp_pkg::K_DEV && shiftIn[7:1] != rsp_pkg::DEV_ID)
              state <= rsp_pkg::DS_WAIT;
            else
            begin
              state <= rsp_pkg::DS_ACK;
              if (kind == rsp_pkg::K_DEV)
                rdMode <= shiftIn[0];
            end
          end
        end
        rsp_pkg::DS_ACK:
        begin
          if (sclFall)
          begin
            bitCnt <= 4'h0;
            if (kind == rsp_pkg::K_DEV && rdMode)
            begin
              state <= rsp_pkg::DS_TX;
              txByte <= memRd;
            end
            else if (kind == rsp_pkg::K_DATA)
              state <= rsp_pkg::DS_WAIT;
            else
            begin
              state <= rsp_pkg::DS_RX;
              kind <= (kind == rsp_pkg::K_DEV) ? rsp_pkg::K_WORD : rsp_pkg::K_DATA;
            end
          end
        end
        rsp_pkg::DS_TX:
        begin
          if (sclFall)
          begin
            txByte <= {txByte[6:0], 1'b0};
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt == rsp_pkg::LAST_BIT)
              state <= rsp_pkg::DS_MACK;
          end
        end
        rsp_pkg::DS_MACK:
        begin
          if (sclRise)
            masterAck <= ~sdaQ;
          else if (sclFall)
          begin
            if (masterAck)
            begin
              state <= rsp_pkg::DS_TX;
              txByte <= memRd;
              bitCnt <= 4'h0;
            end
            else
              state <= rsp_pkg::DS_WAIT;
          end
        end
        rsp_pkg::DS_IDLE, rsp_pkg::DS_WAIT:
          state <= state;
        default:
          state <= rsp_pkg::DS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Address pointer
  always_ff @(posedge clk_link)
  begin
    if (rstL)
      ptr <= rsp_pkg::PTR_RESET;
    else if (byteDone && kind == rsp_pkg::K_WORD)
      ptr <= shiftIn;
    else if (state == rsp_pkg::DS_TX && sclFall && bitCnt == rsp_pkg::LAST_BIT)
      ptr <= (ptr >= rsp_pkg::MEM_LAST) ? rsp_pkg::PTR_RESET : ptr + 8'h01;
  end

  // ==========================================================
  // Storage: clock/control array and user bytes alike
  always_ff @(posedge clk_link)
  begin
    if (rstL)
      for (int i = 0; i < rsp_pkg::MEM_DEPTH; i++)
        mem[i] <= 8'h00;
    else if (byteDone && kind == rsp_pkg::K_DATA && ptr <= rsp_pkg::MEM_LAST)
      mem[ptr[4:0]] <= shiftIn;
  end

  // ==========================================================
  // Data pin drive, open drain
  logic sdaDrv;
  // Registered so the pin never sees decode glitches
  always_ff @(posedge clk_link)
  begin
    if (rstL)
      sdaDrv <= 1'b0;
    else
      sdaDrv <= (state == rsp_pkg::DS_ACK) || (state == rsp_pkg::DS_TX && !txByte[7]);
  end

  assign bus.dSdaOut = 1'b0;
  assign bus.dSdaOe = sdaDrv;

  // ==========================================================
  // Write report into clk_sys: toggle plus held words
  logic wrTgl, tglM, tglQ, tglP;
  logic [7:0] wrAddrL, wrDataL;
  always_ff @(posedge clk_link)
  begin
    if (rstL)
    begin
      wrTgl <= 1'b0;
      wrAddrL <= 8'h00;
      wrDataL <= 8'h00;
    end
    else if (byteDone && kind == rsp_pkg::K_DATA)
    begin
      wrTgl <= ~wrTgl;
      wrAddrL <= ptr;
      wrDataL <= shiftIn;
    end
  end

  // Held words are stable for a whole byte time before the next toggle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tglM <= 1'b0;
      tglQ <= 1'b0;
      tglP <= 1'b0;
      wrStrobe <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
    end
    else
    begin
      tglM <= wrTgl;
      tglQ <= tglM;
      tglP <= tglQ;
      wrStrobe <= tglQ ^ tglP;
      if (tglQ ^ tglP)
      begin
        wrAddr <= wrAddrL;
        wrData <= wrDataL;
      end
    end
  end

endmodule : rsp_device

//--- src/rsp_pkg.sv
// Shared constants and types for the two-wire RTC slave port and its bus master.
// Assumes both ends and the interface are compiled after this package.
package rsp_pkg;

  // ==========================================================
  // Addressing
  localparam logic [6:0] DEV_ID = 7'h6F;         // Fixed 1101111 slave pattern
  localparam logic [7:0] MEM_LAST = 8'h19;       // Highest location before wrap
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int MEM_DEPTH = 26;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // ==========================================================
  // Timing
  localparam int CLK_SYS_NS = 100;
  localparam int SCL_PERIOD_NS = 2500;           // 400 kHz serial clock
  localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);

  // ==========================================================
  // State types
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_RX = 3'h1,
    DS_ACK = 3'h2,
    DS_TX = 3'h3,
    DS_MACK = 3'h4,
    DS_WAIT = 3'h5
  } rsp_dstate_t;

  typedef enum logic [1:0] {
    K_DEV = 2'h0,
    K_WORD = 2'h1,
    K_DATA = 2'h2
  } rsp_kind_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_START = 2'h1,
    MS_BYTE = 2'h2,
    MS_STOP = 2'h3
  } rsp_mstate_t;

  typedef enum logic [2:0] {
    P_DEVW = 3'h0,
    P_WADDR = 3'h1,
    P_DATA = 3'h2,
    P_DEVR = 3'h3,
    P_READ = 3'h4
  } rsp_phase_t;

endpackage : rsp_pkg

//--- src/rsp_if.sv
// Two-wire link between the bus master and the RTC slave port.
// Assumes open-drain data with a pull-up; the master drives the clock.
interface rsp_if;
  logic scl;
  logic mSdaOut;
  logic mSdaOe;
  logic dSdaOut;
  logic dSdaOe;
  logic sda;

  // Wired-AND with pull-up: any enabled low driver wins
  assign sda = ~((mSdaOe & ~mSdaOut) | (dSdaOe & ~dSdaOut));

  modport master (output scl, output mSdaOut, output mSdaOe, input sda);
  modport device (input scl, input sda, output dSdaOut, output dSdaOe);
endinterface : rsp_if

//--- src/rsp_master.sv
// Bus master end: runs byte writes and random reads on the two-wire link.
// Assumes clk_sys at 10 MHz; the serial clock is divided from it.
module rsp_master (
  input wire logic clk_sys,        // System clock
  input wire logic rst,            // Synchronous reset, active high
  input wire logic cmdValid,       // Command offered
  output logic cmdReady,           // Engine idle, command taken
  input wire logic cmdRead,        // 1 random read, 0 byte write
  input wire logic [6:0] cmdDevId, // Slave identifier
  input wire logic [7:0] cmdAddr,  // Word address
  input wire logic [7:0] cmdData,  // Write data
  input wire logic [7:0] cmdCount, // Read length, 0 counts as 1
  output logic rdValid,            // One-cycle pulse per read byte
  output logic [7:0] rdData,       // Read byte
  output logic done,               // One-cycle pulse after stop
  output logic nack,               // Last command saw a missing ack
  rsp_if.master bus                // Two-wire link
);

  rsp_pkg::rsp_mstate_t state;
  rsp_pkg::rsp_phase_t phase;
  logic [3:0] qtrCnt;
  logic [1:0] qtr;
  logic [3:0] bitIdx;
  logic [7:0] txSh;
  logic [7:0] rxByte;
  logic [7:0] left;
  logic isRead;
  logic [6:0] devId;
  logic [7:0] wAddr;
  logic [7:0] wData;
  logic sclDrv;
  logic sdaLow;
  logic sdaM;
  logic sdaQ;
  logic tick;
  logic rxMode;

  assign cmdReady = (state == rsp_pkg::MS_IDLE);
  assign tick = (qtrCnt == rsp_pkg::QTR_LAST);
  assign rxMode = (phase == rsp_pkg::P_READ);
  assign bus.scl = sclDrv;
  assign bus.mSdaOut = 1'b0;
  assign bus.mSdaOe = sdaLow;

  // ==========================================================
  // Data pin synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sdaM <= 1'b1;
      sdaQ <= 1'b1;
    end
    else
    begin
      sdaM <= bus.sda;
      sdaQ <= sdaM;
    end
  end

  // ==========================================================
  // Quarter-period divider
  always_ff @(posedge clk_sys)
  begin
    if (rst || state == rsp_pkg::MS_IDLE)
    begin
      qtrCnt <= 4'h0;
      qtr <= 2'h0;
    end
    else if (tick)
    begin
      qtrCnt <= 4'h0;
      qtr <= qtr + 2'h1;
    end
    else
      qtrCnt <= qtrCnt + 4'h1;
  end

  // ==========================================================
  // Sequencer; data moves in quarter 1 while clock is low
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= rsp_pkg::MS_IDLE;
      phase <= rsp_pkg::P_DEVW;
      bitIdx <= 4'h0;
      txSh <= 8'h00;
      rxByte <= 8'h00;
      left <= 8'h00;
      isRead <= 1'b0;
      devId <= 7'h00;
      wAddr <= 8'h00;
      wData <= 8'h00;
      sclDrv <= 1'b1;
      sdaLow <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 8'h00;
      done <= 1'b0;
      nack <= 1'b0;
    end
    else
    begin
      rdValid <= 1'b0;
      done <= 1'b0;
      case (state)
        rsp_pkg::MS_IDLE:
        begin
          if (cmdValid)
          begin
            state <= rsp_pkg::MS_START;
            phase <= rsp_pkg::P_DEVW;
            isRead <= cmdRead;
            devId <= cmdDevId;
            wAddr <= cmdAddr;
            wData <= cmdData;
            left <= (cmdCount == 8'h00) ? 8'h01 : cmdCount;
            nack <= 1'b0;
          end
        end
        rsp_pkg::MS_START:
        begin
          if (tick)
          begin
            case (qtr)
              // From idle the clock is already high; a pulse there would be stray traffic
              2'h0: sclDrv <= (phase != rsp_pkg::P_DEVR);
              2'h1: sdaLow <= 1'b0;
              2'h2: sclDrv <= 1'b1;
              default:
              begin
                sdaLow <= 1'b1;
                state <= rsp_pkg::MS_BYTE;
                bitIdx <= 4'h0;
                txSh <= {devId, phase == rsp_pkg::P_DEVR};
              end
            endcase
          end
        end
        rsp_pkg::MS_BYTE:
        begin
          if (tick)
          begin
            case (qtr)
              2'h0: sclDrv <= 1'b0;
              2'h1:
              begin
                if (bitIdx < rsp_pkg::BYTE_BITS)
                  sdaLow <= !rxMode && !txSh[7];
                else
                  sdaLow <= rxMode && (left != 8'h01);
              end
              2'h2: sclDrv <= 1'b1;
              default:
              begin
                if (bitIdx < rsp_pkg::BYTE_BITS)
                begin
                  rxByte <= {rxByte[6:0], sdaQ};
                  txSh <= {txSh[6:0], 1'b0};
                  bitIdx <= bitIdx + 4'h1;
                end
                else
                begin
                  bitIdx <= 4'h0;
                  if (!rxMode && sdaQ)
                  begin
                    nack <= 1'b1;
                    state <= rsp_pkg::MS_STOP;
                  end
                  else
                  begin
                    case (phase)
                      rsp_pkg::P_DEVW:
                      begin
                        phase <= rsp_pkg::P_WADDR;
                        txSh <= wAddr;
                      end
                      rsp_pkg::P_WADDR:
                      begin
                        if (isRead)
                        begin
                          state <= rsp_pkg::MS_START;
                          phase <= rsp_pkg::P_DEVR;
                        end
                        else
                        begin
                          phase <= rsp_pkg::P_DATA;
                          txSh <= wData;
                        end
                      end
                      rsp_pkg::P_DATA: state <= rsp_pkg::MS_STOP;
                      rsp_pkg::P_DEVR: phase <= rsp_pkg::P_READ;
                      default:
                      begin
                        rdValid <= 1'b1;
                        rdData <= rxByte;
                        left <= left - 8'h01;
                        if (left == 8'h01)
                          state <= rsp_pkg::MS_STOP;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        rsp_pkg::MS_STOP:
        begin
          if (tick)
          begin
            case (qtr)
              2'h0: sclDrv <= 1'b0;
              2'h1: sdaLow <= 1'b1;
              2'h2: sclDrv <= 1'b1;
              default:
              begin
                sdaLow <= 1'b0;
                state <= rsp_pkg::MS_IDLE;
                done <= 1'b1;
              end
            endcase
          end
        end
        default:
          state <= rsp_pkg::MS_IDLE;
      endcase
    end
  end

endmodule : rsp_master

//--- tb/rsp_asserts.sv
// Concurrent checks on the two-wire link between master and RTC slave port.
// Assumes instantiation beside the interface; everything sampled on clk_sys.
module rsp_asserts (
  input wire logic clk_sys,  // System clock
  input wire logic rst,      // Synchronous reset, active high
  input wire logic pwrReady, // Device power-up done
  input wire logic scl,      // Serial clock
  input wire logic mSdaOe,   // Master pulls data low
  input wire logic dSdaOe,   // Device pulls data low
  input wire logic sda       // Resolved data wire
);
  // ==========================================================
  // Bus decoding
  logic sclQ;
  logic sdaQ;
  logic frame;
  logic [3:0] bitNum;
  logic [2:0] byteIdx;
  logic [7:0] shifter;
  logic rdPhase;
  logic acked;
  logic miss;
  wire logic rise;
  wire logic ninth;
  wire logic startEv;
  wire logic stopEv;
  wire logic idMatch;
  assign rise = scl && !sclQ;
  assign ninth = rise && frame && bitNum == 4'h8;
  assign startEv = scl && sclQ && sdaQ && !sda;
  assign stopEv = scl && sclQ && !sdaQ && sda;
  assign idMatch = shifter[7:1] == rsp_pkg::DEV_ID;

  always_ff @(posedge clk_sys)
  begin
    sclQ <= rst ? 1'b1 : scl;
    sdaQ <= rst ? 1'b1 : sda;
    frame <= rst ? 1'b0 : (startEv ? 1'b1 : (stopEv ? 1'b0 : frame));
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || startEv || stopEv)
    begin
      bitNum <= 4'h0;
    end
    else if (rise)
    begin
      bitNum <= (bitNum == 4'h9) ? 4'h1 : bitNum + 4'h1;
      shifter <= (bitNum < 4'h8) ? {shifter[6:0], sda} : shifter;
    end
  end

  // Pre-start clock rises would count bits; the start clears them again
  always_ff @(posedge clk_sys)
  begin
    if (rst || startEv)
    begin
      byteIdx <= 3'h0;
      miss <= 1'b0;
      acked <= 1'b0;
    end
    else if (ninth)
    begin
      byteIdx <= byteIdx + 3'h1;
      if (byteIdx == 3'h0)
      begin
        rdPhase <= shifter[0];
        acked <= idMatch && pwrReady;
        miss <= !(idMatch && pwrReady);
      end
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_released: assert property ($fell(rst) |-> scl && !mSdaOe && !dSdaOe)
    else $error("link not idle after reset");
  a_dev_stable_high: assert property (scl && sclQ |-> $stable(dSdaOe))
    else $error("device data changed with clock high");
  a_idle_no_drive: assert property (!frame |-> !dSdaOe && scl)
    else $error("link active outside a transfer");
  a_miss_released: assert property (miss |-> !dSdaOe)
    else $error("device drove after refused slave byte");
  a_ack_given: assert property (ninth && ((byteIdx == 3'h0 && idMatch && pwrReady)
    || (byteIdx inside {3'h1, 3'h2} && acked && !rdPhase)) |-> !sda)
    else $error("missing device acknowledge");
  a_mst_release: assert property (ninth && (byteIdx == 3'h0 || !rdPhase) |-> !mSdaOe)
    else $error("master held data in acknowledge slot");
  a_dev_release: assert property (ninth && rdPhase && byteIdx != 3'h0 |-> !dSdaOe)
    else $error("device held data in acknowledge slot");
  a_stop_standby: assert property (stopEv |-> ##1 !dSdaOe [*4])
    else $error("device drove data after stop");

  c_write_ack: cover property (ninth && byteIdx == 3'h2 && !rdPhase && !sda);
  c_last_nack: cover property (ninth && rdPhase && byteIdx != 3'h0 && sda);
  c_miss: cover property (miss);
endmodule : rsp_asserts

//--- tb/rtc_i2c_slave_port_tb_top.sv
// Bench joining the bus master and the RTC slave port across the link.
// Assumes package, interface, both ends and the checker are compiled first.
module rtc_i2c_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 5;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst = 1'b1;
  logic pwrReady = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdRead = 1'b0;
  logic [6:0] cmdDevId = 7'h00;
  logic [7:0] cmdAddr = 8'h00;
  logic [7:0] cmdData = 8'h00;
  logic [7:0] cmdCount = 8'h00;
  logic cmdReady;
  logic rdValid;
  logic done;
  logic nack;
  logic wrStrobe;
  logic [7:0] rdData;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [15:0] wq[$];
  logic [7:0] rq[$];
  logic nq[$];
  logic [7:0] mem [0:25];
  logic [7:0] waddr [7] = '{8'h00, 8'h01, 8'h12, 8'h13, 8'h18, 8'h19, 8'h05};
  int error_cnt = 0;
  int checks_done = 0;
  int doneCnt = 0;
  int seed = 69088;

  rsp_if rsp_if_i ();
  rsp_device rsp_device_i (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
    .pwrReady(pwrReady), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
    .bus(rsp_if_i));
  rsp_master rsp_master_i (.clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdDevId(cmdDevId), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdCount(cmdCount), .rdValid(rdValid), .rdData(rdData),
    .done(done), .nack(nack), .bus(rsp_if_i));
  rsp_asserts rsp_asserts_i (.clk_sys(clk_sys), .rst(rst), .pwrReady(pwrReady),
    .scl(rsp_if_i.scl), .mSdaOe(rsp_if_i.mSdaOe), .dSdaOe(rsp_if_i.dSdaOe),
    .sda(rsp_if_i.sda));

  initial forever #50 clk_sys = ~clk_sys;
  // Link clock offset so its edges never line up with clk_sys
  initial
  begin
    #7;
    forever #24 clk_link = ~clk_link;
  end

  // ==========================================================
  // Reporting and comparison
  task automatic bad(input string msg);
    error_cnt++;
    $display("BAD t=%0t %s", $time, msg);
  endtask : bad

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) bad(msg);
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) bad(msg);
  endtask : cmp_bit

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_sys)
  begin
    if (wrStrobe === 1'b1 && wq.size() == 0) bad("unexpected write");
    else if (wrStrobe === 1'b1)
    begin
      cmp_byte(wrAddr, wq[0][15:8], "write location");
      cmp_byte(wrData, wq[0][7:0], "write value");
      void'(wq.pop_front());
    end
    if (rdValid === 1'b1 && rq.size() == 0) bad("unexpected read byte");
    else if (rdValid === 1'b1) cmp_byte(rdData, rq.pop_front(), "read byte");
    if (done === 1'b1 && nq.size() == 0) bad("unexpected completion");
    else if (done === 1'b1) cmp_bit(nack, nq.pop_front(), "ack outcome");
    if (done === 1'b1) doneCnt++;
  end

  // ==========================================================
  // Stimulus
  task automatic run_cmd(input logic rd, input logic [6:0] id, input logic [7:0] addr,
                         input logic [7:0] cnt, input logic ok);
    logic [7:0] data;
    logic [7:0] p;
    int k;
    int d0;
    data = 8'($random(seed));
    p = addr;
    nq.push_back(!ok);
    if (ok && !rd) mem[addr] = data;
    if (ok && !rd) wq.push_back({addr, data});
    for (k = 0; ok && rd && k < ((cnt == 8'h00) ? 1 : int'(cnt)); k++)
    begin
      rq.push_back(mem[p]);
      p = (p == rsp_pkg::MEM_LAST) ? 8'h00 : p + 8'h01;
    end
    cmp_bit(cmdReady, 1'b1, "engine not idle");
    d0 = doneCnt;
    cmdRead = rd;
    cmdDevId = id;
    cmdAddr = addr;
    cmdData = data;
    cmdCount = cnt;
    cmdValid = 1'b1;
    @(posedge clk_sys);
    #DLY;
    cmdValid = 1'b0;
    for (k = 0; doneCnt == d0 && k < 6000; k++) @(posedge clk_sys);
    if (doneCnt == d0) bad("no completion");
    @(posedge clk_sys);
    #DLY;
  endtask : run_cmd

  initial
  begin
    #4_000_000;
    bad("watchdog expired");
    summarize();
  end

  initial
  begin
    for (int i = 0; i < 26; i++) mem[i] = 8'h00;
    repeat (5) @(posedge clk_sys);
    #DLY;
    rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #DLY;
    run_cmd(1'b0, rsp_pkg::DEV_ID, 8'h12, 8'h00, 1'b0);
    pwrReady = 1'b1;
    repeat (3) @(posedge clk_sys);
    #DLY;
    $display("test power done");
    for (int i = 0; i < 7; i++) run_cmd(1'b0, rsp_pkg::DEV_ID, waddr[i], 8'h00, 1'b1);
    $display("test write done");
    run_cmd(1'b1, rsp_pkg::DEV_ID, 8'h12, 8'h08, 1'b1);
    run_cmd(1'b1, rsp_pkg::DEV_ID, 8'h17, 8'h05, 1'b1);
    run_cmd(1'b1, rsp_pkg::DEV_ID, 8'h02, 8'h00, 1'b1);
    $display("test read done");
    run_cmd(1'b0, 7'h6E, 8'h12, 8'h00, 1'b0);
    run_cmd(1'b1, 7'h2F, 8'h12, 8'h02, 1'b0);
    run_cmd(1'b1, rsp_pkg::DEV_ID, 8'h12, 8'h01, 1'b1);
    $display("test mismatch done");
    cmp_bit(wq.size() == 0 && rq.size() == 0 && nq.size() == 0, 1'b1, "notes left");
    summarize();
  end
endmodule : rtc_i2c_slave_port_tb_top
